// file: hdl/io_mux_maint_pkg.sv
// types shared by the maintenance control
package io_mux_maint_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SCRATCH,
    ST_MEM,
    ST_DESC
  } maint_state_e;
endpackage

// file: hdl/io_mux_maint_regs.svh
// register offsets, field positions, reset values and timing counts of the maintenance control
`ifndef IO_MUX_MAINT_REGS_SVH
`define IO_MUX_MAINT_REGS_SVH
// ***********************************
// register offsets
// ***********************************
`define OFS_CTRL      8'h00
`define OFS_START     8'h04
`define OFS_STATUS    8'h08
`define OFS_CMD_LO    8'h0C
`define OFS_CMD_HI    8'h10
`define OFS_DATA_LO   8'h14
`define OFS_DATA_HI   8'h18
`define OFS_TAG       8'h1C
`define OFS_KEY       8'h20
`define OFS_LINK      8'h24
`define OFS_TOD_LO    8'h28
`define OFS_TOD_HI    8'h2C
`define OFS_MADDR     8'h30
`define OFS_MRD_LO    8'h34
`define OFS_MRD_HI    8'h38
`define OFS_FLAGS     8'h3C
`define OFS_DIAG      8'h40
`define OFS_SPRD0     8'h44
`define OFS_SPRD1     8'h48
`define OFS_SPRD2     8'h4C
`define OFS_SPRD3     8'h50
// ***********************************
// control fields
// ***********************************
`define CTRL_LOCAL    0
`define CTRL_DISPLAY  1
`define CTRL_CLKRUN   2
`define CTRL_WRITE    3
`define CTRL_MEM      4
`define CTRL_ENABLE   5
`define CTRL_RECYCLE  6
`define CTRL_ERRSTOP  7
`define CTRL_REQINH   8
`define CTRL_CNTINH   9
`define CTRL_DESCEN   10
`define CTRL_CARDEN   11
`define CTRL_TESTTYPE 12
`define CTRL_W        13
`define CTRL_RESET    13'h0000
`define START_GO      0
`define START_CARD    1
`define TAG_SLOT_LSB  0
`define TAG_VAL_LSB   4
`define DIAG_W        16
// ***********************************
// timing
// ***********************************
`define CLK_MHZ       200
`define TOD_TICK_NS   1000
`define TOD_TICK_CYC  ((`TOD_TICK_NS * `CLK_MHZ) / 1000)
`endif

// file: hdl/io_mux_maintenance_control.sv
// maintenance control of the io multiplexor with apb register access
// Operation
// - maintenance runs only in local mode, display active and clock running
// - supports scratch pad, main memory, descriptor execution and card test
// - scratch pad write stores command and data as one 112 bit word
// - direction and target selectors act only while enable is set
// - single cycle mode does one transfer per start
// - recycle repeats the transfer until recycle is cleared
// - scratch read uses the write path but loads no command or data
// - memory write takes address from command, word from data; data kept
// - request inhibit blocks setting the memory access needed flag
// - error stop halts recycling on parity error or timeout, sets error
// - start while error is set clears it and restarts
// - count inhibit keeps the address, otherwise it advances each cycle
// - command register is 60 bits
// - ten tag sets each with read flag, five tag pair flags
// - 5 bit key selects slots, link register supplies key on initiate
// - time of day has 44 bits, 36 counting, all used in card test
// - diagnostic row meaning depends on the selected test type
//
// Added by the designer: the register offsets and the APB slave port.
`include "io_mux_maint_regs.svh"
module io_mux_maintenance_control
  import io_mux_maint_pkg::*;
#(
  parameter int CMD_W   = 60,
  parameter int DATA_W  = 51,
  parameter int SP_W    = 112,
  parameter int ADDR_W  = 20,
  parameter int SLOTS   = 10,
  parameter int KEY_W   = 5,
  parameter int TOD_W   = 44,
  parameter int TODC_W  = 36
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic              mem_parity_err,
  input  wire logic              mem_timeout,
  output logic                   desc_start,
  input  wire logic              desc_done,
  input  wire logic              desc_error,
  input  wire logic [TOD_W-1:0]  card_result,
  output logic                   test_type_flag
);

  localparam int TICK_CYC = (`TOD_TICK_CYC < 1) ? 1 : `TOD_TICK_CYC;
  // ***********************************
  // state
  // ***********************************
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic [`CTRL_W-1:0]  ctrl_r;
  logic [CMD_W-1:0]    cmd_r;
  logic [DATA_W-1:0]   data_r;
  logic [KEY_W-1:0]    tag_r [SLOTS];
  logic [KEY_W-1:0]    slot_key_reg_r;
  logic [KEY_W-1:0]    key_link_reg_r;
  logic [SP_W-1:0]     scratch_r [SLOTS];
  logic [SP_W-1:0]     sp_rd_r;
  logic [SLOTS-1:0]    read_scratch_flag_r;
  logic [SLOTS/2-1:0]  tag_pair_flag_r;
  logic [TOD_W-1:0]    time_of_day_reg_r;
  logic [15:0]         tick_cnt_r;
  logic [TOD_W-1:0]    card_meta_r;
  logic [TOD_W-1:0]    card_sync_r;
  logic [`DIAG_W-1:0]  diag_r;
  maint_state_e        state_r;
  logic                mem_access_needed_flag_r;
  logic                mem_we_r;
  logic [ADDR_W-1:0]   mem_addr_r;
  logic [DATA_W-1:0]   mem_rd_r;
  logic                error_r;
  logic                desc_start_r;
  // ***********************************
  // apb decode
  // ***********************************
  wire       acc      = psel & penable;
  wire       fire     = acc & pready_r;
  wire       wr       = fire & pwrite;
  wire       hit      = (paddr[1:0] == 2'b00) && (paddr <= `OFS_SPRD3);
  wire       wr_ctrl  = wr && paddr == `OFS_CTRL;
  wire       wr_start = wr && paddr == `OFS_START;
  wire       wr_cmdl  = wr && paddr == `OFS_CMD_LO;
  wire       wr_cmdh  = wr && paddr == `OFS_CMD_HI;
  wire       wr_datl  = wr && paddr == `OFS_DATA_LO;
  wire       wr_dath  = wr && paddr == `OFS_DATA_HI;
  wire       wr_tag   = wr && paddr == `OFS_TAG;
  wire       wr_key   = wr && paddr == `OFS_KEY;
  wire       wr_link  = wr && paddr == `OFS_LINK;
  wire       wr_todl  = wr && paddr == `OFS_TOD_LO;
  wire       wr_todh  = wr && paddr == `OFS_TOD_HI;
  wire       wr_flags = wr && paddr == `OFS_FLAGS;
  wire       wr_diag  = wr && paddr == `OFS_DIAG;
  wire       start_go = wr_start & pwdata[`START_GO];
  wire [3:0] tag_slot = pwdata[`TAG_SLOT_LSB +: 4];
  wire [KEY_W-1:0] tag_val = pwdata[`TAG_VAL_LSB +: KEY_W];
  // ***********************************
  // operation qualifiers
  // ***********************************
  wire ops_ok   = ctrl_r[`CTRL_LOCAL] & ctrl_r[`CTRL_DISPLAY] & ctrl_r[`CTRL_CLKRUN];
  wire op_en    = ops_ok & ctrl_r[`CTRL_ENABLE];
  wire op_mem   = ctrl_r[`CTRL_MEM];
  wire op_write = ctrl_r[`CTRL_WRITE];
  wire recycle  = ctrl_r[`CTRL_RECYCLE];
  wire req_inh  = ctrl_r[`CTRL_REQINH];
  wire mem_end  = mem_ack | mem_timeout;
  wire mem_err  = mem_end & (mem_parity_err | mem_timeout);
  wire desc_err = desc_done & desc_error;
  wire stop_err = recycle & ctrl_r[`CTRL_ERRSTOP] & ((state_r == ST_MEM & mem_err) |
                                                    (state_r == ST_DESC & desc_err));
  wire again    = recycle & ops_ok & ~stop_err;
  // ***********************************
  // scratch pad slot match
  // ***********************************
  logic [SLOTS-1:0]   slot_hit;
  logic [SLOTS/2-1:0] pair_hit;
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      assign slot_hit[gi] = (tag_r[gi] == slot_key_reg_r);
      if (gi % 2 == 1) begin : g_pair
        assign pair_hit[gi/2] = slot_hit[gi] | slot_hit[gi-1];
      end
    end
  endgenerate

  wire sp_go    = (state_r == ST_SCRATCH);
  wire sp_wr_go = sp_go & op_write;
  wire sp_rd_go = sp_go & ~op_write;
  wire [SP_W-1:0] sp_word = SP_W'({cmd_r, data_r});

  logic [SP_W-1:0] sp_sel;
  always_comb begin
    sp_sel = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (slot_hit[i]) begin
        sp_sel = scratch_r[i];
      end
    end
  end
  // ***********************************
  // read mux
  // ***********************************
  wire [31:0] status_w = {27'h0000000, desc_start_r, mem_access_needed_flag_r, error_r,
                          state_r != ST_IDLE, ops_ok};
  wire [31:0] rd_mux =
    (paddr == `OFS_CTRL)    ? 32'(ctrl_r) :
    (paddr == `OFS_STATUS)  ? status_w :
    (paddr == `OFS_CMD_LO)  ? cmd_r[31:0] :
    (paddr == `OFS_CMD_HI)  ? 32'(cmd_r[CMD_W-1:32]) :
    (paddr == `OFS_DATA_LO) ? data_r[31:0] :
    (paddr == `OFS_DATA_HI) ? 32'(data_r[DATA_W-1:32]) :
    (paddr == `OFS_KEY)     ? 32'(slot_key_reg_r) :
    (paddr == `OFS_LINK)    ? 32'(key_link_reg_r) :
    (paddr == `OFS_TOD_LO)  ? time_of_day_reg_r[31:0] :
    (paddr == `OFS_TOD_HI)  ? 32'(time_of_day_reg_r[TOD_W-1:32]) :
    (paddr == `OFS_MADDR)   ? 32'(mem_addr_r) :
    (paddr == `OFS_MRD_LO)  ? mem_rd_r[31:0] :
    (paddr == `OFS_MRD_HI)  ? 32'(mem_rd_r[DATA_W-1:32]) :
    (paddr == `OFS_FLAGS)   ? 32'({tag_pair_flag_r, read_scratch_flag_r}) :
    (paddr == `OFS_DIAG)    ? 32'({test_type_flag, diag_r}) :
    (paddr == `OFS_SPRD0)   ? sp_rd_r[31:0] :
    (paddr == `OFS_SPRD1)   ? sp_rd_r[63:32] :
    (paddr == `OFS_SPRD2)   ? sp_rd_r[95:64] :
    (paddr == `OFS_SPRD3)   ? 32'(sp_rd_r[SP_W-1:96]) :
    32'h00000000;
  // ***********************************
  // apb slave
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~hit;
      if (acc & ~pready_r) begin
        prdata_r <= hit ? rd_mux : 32'h00000000;
      end
    end
  end
  // ***********************************
  // software registers
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r         <= `CTRL_RESET;
      cmd_r          <= '0;
      data_r         <= '0;
      slot_key_reg_r <= '0;
      key_link_reg_r <= '0;
      diag_r         <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= pwdata[`CTRL_W-1:0];
      if (wr_cmdl) cmd_r[31:0] <= pwdata;
      if (wr_cmdh) cmd_r[CMD_W-1:32] <= pwdata[CMD_W-33:0];
      if (wr_datl) data_r[31:0] <= pwdata;
      if (wr_dath) data_r[DATA_W-1:32] <= pwdata[DATA_W-33:0];
      if (wr_link) key_link_reg_r <= pwdata[KEY_W-1:0];
      if (wr_diag) diag_r <= pwdata[`DIAG_W-1:0];
      if (start_go && ops_ok && !op_en && ctrl_r[`CTRL_DESCEN]) begin
        slot_key_reg_r <= key_link_reg_r;
      end else if (wr_key) begin
        slot_key_reg_r <= pwdata[KEY_W-1:0];
      end
    end
  end

  assign test_type_flag = ctrl_r[`CTRL_TESTTYPE];
  // ***********************************
  // tags and scratch pad
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        tag_r[i]     <= '0;
        scratch_r[i] <= '0;
      end
      read_scratch_flag_r <= '0;
      tag_pair_flag_r     <= '0;
      sp_rd_r             <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        if (wr_tag && tag_slot == 4'(i)) tag_r[i] <= tag_val;
        if (sp_wr_go && slot_hit[i]) scratch_r[i] <= sp_word;
        if (sp_rd_go && slot_hit[i]) begin
          read_scratch_flag_r[i] <= 1'b1;
        end else if (wr_flags && pwdata[i]) begin
          read_scratch_flag_r[i] <= 1'b0;
        end
      end
      if (sp_go) tag_pair_flag_r <= pair_hit;
      if (sp_rd_go) sp_rd_r <= sp_sel;
    end
  end
  // ***********************************
  // time of day and card test
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_meta_r <= '0;
      card_sync_r <= '0;
    end else begin
      card_meta_r <= card_result;
      card_sync_r <= card_meta_r;
    end
  end

  wire card_go = wr_start & pwdata[`START_CARD] & ops_ok & ctrl_r[`CTRL_CARDEN];
  wire tick    = (tick_cnt_r == 16'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r        <= '0;
      time_of_day_reg_r <= '0;
    end else begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (card_go) begin
        time_of_day_reg_r <= card_sync_r;
      end else if (wr_todl) begin
        time_of_day_reg_r[31:0] <= pwdata;
      end else if (wr_todh) begin
        time_of_day_reg_r[TOD_W-1:32] <= pwdata[TOD_W-33:0];
      end else if (tick && !ctrl_r[`CTRL_CARDEN]) begin
        time_of_day_reg_r[TODC_W-1:0] <= time_of_day_reg_r[TODC_W-1:0] + TODC_W'(1);
      end
    end
  end
  // ***********************************
  // sequencer
  // ***********************************
  wire start_ok  = start_go & op_en & (state_r == ST_IDLE);
  wire start_mem = start_ok & op_mem & ~req_inh;
  wire mem_next  = (state_r == ST_MEM) & mem_end & again & op_en & ~req_inh;
  wire set_mem_access_needed_flag  = start_mem | mem_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ST_IDLE;
      desc_start_r <= 1'b0;
    end else begin
      desc_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= op_mem ? (req_inh ? ST_IDLE : ST_MEM) : ST_SCRATCH;
          end else if (start_go && ops_ok && ctrl_r[`CTRL_DESCEN]) begin
            state_r      <= ST_DESC;
            desc_start_r <= 1'b1;
          end
        end
        ST_SCRATCH: begin
          state_r <= (again && op_en) ? ST_SCRATCH : ST_IDLE;
        end
        ST_MEM: begin
          if (mem_end) begin
            state_r <= mem_next ? ST_MEM : ST_IDLE;
          end
        end
        ST_DESC: begin
          if (desc_done) begin
            state_r      <= again ? ST_DESC : ST_IDLE;
            desc_start_r <= again;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // ***********************************
  // memory port and error flip-flop
  // ***********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_access_needed_flag_r <= 1'b0;
      mem_we_r                 <= 1'b0;
      mem_addr_r               <= '0;
      mem_rd_r                 <= '0;
      error_r                  <= 1'b0;
    end else begin
      if (set_mem_access_needed_flag) begin
        mem_access_needed_flag_r <= 1'b1;
      end else if (mem_end) begin
        mem_access_needed_flag_r <= 1'b0;
      end
      if (start_mem) begin
        mem_we_r   <= op_write;
        mem_addr_r <= cmd_r[ADDR_W-1:0];
      end else if (state_r == ST_MEM && mem_end && !ctrl_r[`CTRL_CNTINH]) begin
        mem_addr_r <= mem_addr_r + ADDR_W'(1);
      end
      if (state_r == ST_MEM && mem_ack && !mem_we_r) mem_rd_r <= mem_rdata;
      if (stop_err) begin
        error_r <= 1'b1;
      end else if (start_go && ops_ok) begin
        error_r <= 1'b0;
      end
    end
  end
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign mem_req    = mem_access_needed_flag_r;
  assign mem_we     = mem_we_r;
  assign mem_addr   = mem_addr_r;
  assign mem_wdata  = data_r;
  assign desc_start = desc_start_r;

endmodule // io_mux_maintenance_control

// file: test/io_mux_maint_chk.sv
// port assertions of the maintenance control
`include "io_mux_maint_regs.svh"
module io_mux_maint_chk #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 51
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic              mem_ack,
  input wire logic              mem_parity_err,
  input wire logic              mem_timeout,
  input wire logic              desc_start,
  input wire logic              test_type_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************
  // register shadows
  // ***********************************
  logic [12:0]       ctrl_r;
  logic [ADDR_W-1:0] cmd_r;
  logic [DATA_W-1:0] data_r;
  wire wr_go = psel & penable & pready & pwrite;
  wire run   = ctrl_r[0] & ctrl_r[1] & ctrl_r[2];
  wire start = wr_go & (paddr == `OFS_START) & pwdata[0];
  wire fail  = mem_timeout | (mem_ack & mem_parity_err);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      cmd_r  <= '0;
      data_r <= '0;
    end else if (wr_go) begin
      if (paddr == `OFS_CTRL) ctrl_r <= pwdata[12:0];
      if (paddr == `OFS_CMD_LO) cmd_r <= pwdata[ADDR_W-1:0];
      if (paddr == `OFS_DATA_LO) data_r[31:0] <= pwdata;
      if (paddr == `OFS_DATA_HI) data_r[DATA_W-1:32] <= pwdata[DATA_W-33:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***********************************
  // properties
  // ***********************************
  property p_gate; !run |-> !$rose(mem_req) && !desc_start; endproperty
  a_gate: assert property (p_gate) else $error("maintenance activity outside local mode");
  property p_inhibit; ctrl_r[8] |-> !$rose(mem_req); endproperty
  a_inhibit: assert property (p_inhibit) else $error("memory request raised under inhibit");
  property p_start; start && run && ctrl_r[5] && ctrl_r[4] && !ctrl_r[8] && !mem_req |=> mem_req; endproperty
  a_start: assert property (p_start) else $error("start did not raise memory request");
  property p_src; $rose(mem_req) |-> mem_addr == cmd_r && mem_we == ctrl_r[3] && mem_wdata == data_r; endproperty
  a_src: assert property (p_src) else $error("memory cycle source wrong");
  property p_step; mem_req && mem_ack && !ctrl_r[9] |=> mem_addr == $past(mem_addr) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("address not advanced by one");
  property p_hold; mem_req && mem_ack && ctrl_r[9] |=> $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("address moved under count inhibit");
  property p_single; mem_req && (mem_ack || mem_timeout) && !ctrl_r[6] |=> !mem_req; endproperty
  a_single: assert property (p_single) else $error("extra cycle in single mode");
  property p_recycle; mem_req && mem_ack && !fail && run && ctrl_r[5] && ctrl_r[6] && !ctrl_r[8] |=> mem_req; endproperty
  a_recycle: assert property (p_recycle) else $error("recycle did not repeat");
  property p_errstop; mem_req && fail && ctrl_r[7] |=> !mem_req [*2]; endproperty
  a_errstop: assert property (p_errstop) else $error("recycle not halted on error");
  property p_desc; desc_start |=> !desc_start; endproperty
  a_desc: assert property (p_desc) else $error("descriptor start longer than one cycle");
  property p_type; $stable(ctrl_r[12]) [*2] |-> test_type_flag == ctrl_r[12]; endproperty
  a_type: assert property (p_type) else $error("test type flag differs from control");
endmodule // io_mux_maint_chk
bind io_mux_maintenance_control io_mux_maint_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_parity_err(mem_parity_err), .mem_timeout(mem_timeout),
  .desc_start(desc_start), .test_type_flag(test_type_flag));

// file: test/io_mux_maintenance_control_tb_top.sv
// self-checking bench of the maintenance control
`include "io_mux_maint_regs.svh"
module io_mux_maintenance_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import io_mux_maint_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [43:0] card_result = 44'h0;
  logic [3:0]  lat = 4'h0;
  logic        bad_par = 1'b0, bad_to = 1'b0, err;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, mem_parity_err, mem_timeout;
  logic        desc_start, desc_done, desc_error, test_type_flag;
  logic [19:0] mem_addr, last_addr, adr;
  logic [50:0] mem_wdata, mem_rdata, last_wdata, dat, ex;
  int          acks, descs, n, k, seed = 41, errors = 0, checks = 0;
  always #2.5 pclk = ~pclk;
  io_mux_maintenance_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_parity_err, .mem_timeout,
    .desc_start, .desc_done, .desc_error, .card_result, .test_type_flag);
  io_mux_mem_model model (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .desc_start, .lat,
    .bad_par, .bad_to, .mem_ack, .mem_parity_err, .mem_timeout, .mem_rdata, .desc_done, .desc_error, .acks,
    .descs, .last_addr, .last_wdata);
  // ***********************************
  // tasks
  // ***********************************
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int cnt;
    cnt = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      cnt++;
    end while (pready !== 1'b1 && cnt < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (cnt >= 20) chk("pready", 1, pready);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic go;
    wr(`OFS_START, 32'h1);
    settle();
  endtask
  task automatic settle;
    k = 0;
    repeat (2) @(posedge pclk);
    while (mem_req === 1'b1 && k < 500) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  // ***********************************
  // scenarios
  // ***********************************
  initial begin
    card_result <= 44'({$random(seed), $random(seed)});
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl reset", `OFS_CTRL, 32'h0);
    apb(1'b0, 8'h54, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    wr(`OFS_CMD_HI, 32'hFFFFFFFF);
    rdc("cmd hi", `OFS_CMD_HI, 32'h0FFFFFFF);
    wr(`OFS_DATA_HI, 32'hFFFFFFFF);
    rdc("data hi", `OFS_DATA_HI, 32'h0007FFFF);
    repeat (4) begin
      adr = 20'($random(seed));
      dat = 51'({$random(seed), $random(seed)});
      lat <= 4'($random(seed));
      wr(`OFS_CMD_LO, {12'h000, adr});
      wr(`OFS_DATA_LO, dat[31:0]);
      wr(`OFS_DATA_HI, {13'h0, dat[50:32]});
      wr(`OFS_CTRL, 32'h3F);
      n = acks;
      go();
      chk("one cycle", n + 1, acks);
      chk("write addr", adr, last_addr);
      chk("write word", dat, last_wdata);
      rdc("data kept", `OFS_DATA_LO, dat[31:0]);
      wr(`OFS_CTRL, 32'h37);
      go();
      ex = {adr[10:0], ~adr, adr};
      rdc("read lo", `OFS_MRD_LO, ex[31:0]);
      rdc("read hi", `OFS_MRD_HI, {13'h0, ex[50:32]});
    end
    n = acks;
    wr(`OFS_CTRL, 32'h13F);
    go();
    wr(`OFS_CTRL, 32'h3E);
    go();
    chk("no cycle", n, acks);
    wr(`OFS_CMD_LO, 32'h100);
    wr(`OFS_TAG, 32'h0);
    wr(`OFS_KEY, 32'h0);
    wr(`OFS_CTRL, 32'h2F);
    go();
    wr(`OFS_CTRL, 32'h27);
    go();
    rdc("scratch 0", `OFS_SPRD0, dat[31:0]);
    rdc("scratch 1", `OFS_SPRD1, {13'h100, dat[50:32]});
    apb(1'b0, `OFS_FLAGS, 32'h0);
    chk("read flag", 1, rd[0]);
    for (int i = 0; i < 2; i++) begin
      n = acks;
      wr(`OFS_CTRL, i ? 32'h277 : 32'h77);
      wr(`OFS_START, 32'h1);
      repeat (40) @(posedge pclk);
      wr(`OFS_CTRL, 32'h37);
      settle();
      chk("recycle ran", 1, acks - n > 2);
      adr = i ? 20'h100 : 20'(32'h100 + acks - n - 1);
      chk("recycle addr", adr, last_addr);
    end
    for (int f = 0; f < 2; f++) begin
      bad_par <= !f;
      bad_to <= f;
      wr(`OFS_CTRL, 32'h2F7);
      go();
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("error set", 1, rd[2]);
      bad_par <= 1'b0;
      bad_to <= 1'b0;
      wr(`OFS_START, 32'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("error clear", 0, rd[2]);
      chk("restart", 1, mem_req);
      wr(`OFS_CTRL, 32'h37);
      go();
    end
    n = descs;
    wr(`OFS_CTRL, 32'h407);
    go();
    repeat (4) @(posedge pclk);
    chk("descriptor", n + 1, descs);
    wr(`OFS_CTRL, 32'h1807);
    wr(`OFS_START, 32'h2);
    rdc("tod lo", `OFS_TOD_LO, card_result[31:0]);
    rdc("tod hi", `OFS_TOD_HI, {20'h0, card_result[43:32]});
    chk("test type", 1, test_type_flag);
    complete_run();
  end
endmodule // io_mux_maintenance_control_tb_top

// file: test/io_mux_mem_model.sv
// main memory and channel responder model
module io_mux_mem_model (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         mem_req,
  input wire logic         mem_we,
  input wire logic [19:0]  mem_addr,
  input wire logic [50:0]  mem_wdata,
  input wire logic         desc_start,
  input wire logic [3:0]   lat,
  input wire logic         bad_par,
  input wire logic         bad_to,
  output logic             mem_ack,
  output logic             mem_parity_err,
  output logic             mem_timeout,
  output logic [50:0]      mem_rdata,
  output logic             desc_done,
  output logic             desc_error,
  output int               acks,
  output int               descs,
  output logic [19:0]      last_addr,
  output logic [50:0]      last_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  logic       dpend_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, mem_parity_err, mem_timeout, desc_done, desc_error, dpend_r} <= '0;
      {mem_rdata, last_addr, last_wdata, wait_r} <= '0;
      acks <= 0;
      descs <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_timeout <= 1'b0;
      mem_parity_err <= 1'b0;
      desc_done <= 1'b0;
      desc_error <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && !mem_timeout) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= lat) begin
          wait_r <= 4'h0;
          mem_ack <= !bad_to;
          mem_timeout <= bad_to;
          mem_parity_err <= bad_par;
          acks <= acks + 1;
          last_addr <= mem_addr;
          if (mem_we) last_wdata <= mem_wdata;
          else mem_rdata <= {mem_addr[10:0], ~mem_addr, mem_addr};
        end
      end
      if (dpend_r) begin
        desc_done <= 1'b1;
        desc_error <= bad_par;
        descs <= descs + 1;
      end
      dpend_r <= desc_start;
    end
  end
endmodule // io_mux_mem_model
